// >>> logic/ast_regs.vh
// constants for the async serial transceiver: register indices, fields, frame timing
// assumes a 32-bit word bus where byte address = 4 * register index
//
// How it works
// - after a non-break framing error, act as if a stop bit came and restart.
// - force three one-valued start qualifiers so the next start is accepted at once.
// - after a break, a real high bit must be seen before any start.
// - transmit bit period is sixteen receiver sample ticks.
// - data register reads the receive holder and writes the transmit holder.
// - receive-full sets when a byte moves into the receive holder.
// - bits travel least significant first in both directions.
// - holder moves to shifter only after the current frame finishes.
// - word-length bit picks eight or nine data bits; reset leaves it.
// - ninth received bit in ctrl one bit 7, ninth sent bit in bit 6.
// - wake select chooses idle-line wake or address-bit wake; reset leaves it.
// - wake-up acts only while the sleep bit is set.
// - ctrl two enables gate the four sources onto one interrupt.
// - setting transmit enable from clear sends a preamble of ten or eleven ones.
// - clearing transmit enable mid-byte finishes the byte, then floats the pin.
// - clear then set mid-byte finishes the byte, then sends a new preamble.
// - receiver disable stops reception and inhibits all receive flags.
// - while asleep no receive flag is set except by the waking address byte, and set flags stay set.
// - idle wake clears sleep after ten or eleven ones; no sleep on idle line.
// - address wake clears sleep, stores the address byte, sets receive-full.
// - break sends zeros in whole frames, then at least one high bit.
// - receiver samples the line at sixteen times the bit rate.
// - bits sampled at ticks 8, 9, 10 with majority vote; disagreement is noise.
// - transmit-empty set by reset, cleared by status read then data write.
// - receive-full cleared by status read then data read; reset clears it.
`ifndef AST_REGS_VH
`define AST_REGS_VH

// ****************************************************
// register indices (byte address is four times these)
// ****************************************************
`define AST_IDX_BAUD      6'h0D
`define AST_IDX_CTRL_ONE  6'h0E
`define AST_IDX_CTRL_TWO  6'h0F
`define AST_IDX_STATUS    6'h10
`define AST_IDX_DATA      6'h11

// ****************************************************
// field positions
// ****************************************************
`define AST_C1_RX_NINE    7
`define AST_C1_TX_NINE    6
`define AST_C1_WORD9      4
`define AST_C1_WAKE_ADDR  3
`define AST_C2_TXE_IE     7
`define AST_C2_TXD_IE     6
`define AST_C2_RXF_IE     5
`define AST_C2_IDLE_IE    4
`define AST_C2_TX_ON      3
`define AST_C2_RX_ON      2
`define AST_C2_SLEEP      1
`define AST_C2_BREAK      0

// ****************************************************
// reset values and frame timing
// ****************************************************
`define AST_CTRL_TWO_RST  8'h00
`define AST_BAUD_RST      8'h00
`define AST_FRAME_8       4'hA
`define AST_FRAME_9       4'hB
`define AST_TICKS_PER_BIT 5'h10
`define AST_SMP_A         4'h8
`define AST_SMP_B         4'h9
`define AST_SMP_C         4'hA
`define AST_QUALIFIERS    2'h3

`endif

// >>> logic/ast_top.v
// async serial transceiver: avalon-mm slave, 16x receiver, transmitter, flags
// assumes one clock, rx_pin asynchronous, tx pin resolved outside from oe

`include "ast_regs.vh"

module ast_top
#(
   parameter TICK_BASE = 16'h0001   // clocks per unit of the baud divider
)
(
   input  wire        clk,
   input  wire        rst_b,
   input  wire        ce,
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg         avs_waitrequest,
   output reg  [31:0] avs_readdata,
   input  wire        rx_pin,
   output reg         tx_pin_o,
   output reg         tx_pin_oe,
   output reg         irq_r
);

   // ****************************************************
   // decode helpers
   // ****************************************************
   // prescaler code to divide factor
   function [3:0] presc_div;
      input [1:0] code;
      begin
         case (code)
            2'h0:    presc_div = 4'h1;
            2'h1:    presc_div = 4'h3;
            2'h2:    presc_div = 4'h4;
            default: presc_div = 4'hD;
         endcase
      end
   endfunction

   // majority of three
   function maj3;
      input a;
      input b;
      input c;
      begin
         maj3 = (a & b) | (a & c) | (b & c);
      end
   endfunction

   // ****************************************************
   // registers
   // ****************************************************
   reg  [7:0]  baud_r;
   reg  [7:0]  ctrl_two_r;
   reg         word9_r;        // not reset
   reg         wake_addr_r;    // not reset
   reg         tx_bit_nine_r;  // not reset
   reg         rx_bit_nine_r;  // not reset
   reg  [7:0]  rx_holding_r;   // not reset
   reg  [7:0]  tx_holding_r;   // not reset
   reg         tx_empty_r;
   reg         tx_done_r;
   reg         rx_full_r;
   reg         idle_r;
   reg         overrun_r;
   reg         noise_r;
   reg         fault_r;
   reg  [6:0]  arm_r;          // status bits seen set by a status read

   wire        tx_on      = ctrl_two_r[`AST_C2_TX_ON];
   wire        rx_on      = ctrl_two_r[`AST_C2_RX_ON];
   wire        rx_sleep   = ctrl_two_r[`AST_C2_SLEEP];
   wire        send_break = ctrl_two_r[`AST_C2_BREAK];
   wire [3:0]  frame_len  = word9_r ? `AST_FRAME_9 : `AST_FRAME_8;
   wire [7:0]  status     = {tx_empty_r, tx_done_r, rx_full_r, idle_r,
                             overrun_r, noise_r, fault_r, 1'b0};

   // ****************************************************
   // bus handshake
   // ****************************************************
   wire        req      = avs_read | avs_write;
   wire        accept   = req & ~avs_waitrequest;
   wire [5:0]  idx      = avs_address[7:2];
   wire        wr_lo    = accept & avs_write & avs_byteenable[0];
   wire        rd_acc   = accept & avs_read;
   wire        wr_data  = wr_lo & (idx == `AST_IDX_DATA);
   wire        rd_data  = rd_acc & (idx == `AST_IDX_DATA);
   wire        rd_stat  = rd_acc & (idx == `AST_IDX_STATUS);
   wire        wr_ctl2  = wr_lo & (idx == `AST_IDX_CTRL_TWO);
   reg  [7:0]  rd_mux;

   // read data selection, unmapped reads as zero
   always @*
   begin
      case (idx)
         `AST_IDX_BAUD:     rd_mux = baud_r;
         `AST_IDX_CTRL_ONE: rd_mux = {rx_bit_nine_r, tx_bit_nine_r, 1'b0, word9_r,
                                      wake_addr_r, 3'h0};
         `AST_IDX_CTRL_TWO: rd_mux = ctrl_two_r;
         `AST_IDX_STATUS:   rd_mux = status;
         `AST_IDX_DATA:     rd_mux = rx_holding_r;
         default:           rd_mux = 8'h00;
      endcase
   end

   // one wait cycle, then a single accept cycle
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end
      else if (ce)
      begin
         if (req & avs_waitrequest)
         begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= {24'h000000, rd_mux};
         end
         else
            avs_waitrequest <= 1'b1;
      end
   end

   // ****************************************************
   // baud tick: 16x sample tick and bit tick
   // ****************************************************
   reg  [15:0] div_cnt_r;
   reg  [3:0]  tx_sub_r;
   reg         smp_tick_r;
   wire [15:0] div_pre = {12'h000, presc_div(baud_r[5:4])} * {8'h00, (8'h01 << baud_r[2:0])};
   wire [15:0] div_lim = div_pre * TICK_BASE;
   wire        tx_bit_tick = smp_tick_r & (tx_sub_r == 4'hF);

   // sample tick every div_lim clocks; tx bit every 16 sample ticks
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         div_cnt_r  <= 16'h0000;
         tx_sub_r   <= 4'h0;
         smp_tick_r <= 1'b0;
      end
      else if (ce)
      begin
         smp_tick_r <= (div_cnt_r >= div_lim - 16'h0001);
         div_cnt_r  <= (div_cnt_r >= div_lim - 16'h0001) ? 16'h0000 : div_cnt_r + 16'h0001;
         if (smp_tick_r)
            tx_sub_r <= tx_sub_r + 4'h1;
      end
   end

   // ****************************************************
   // receiver
   // ****************************************************
   reg         rx_s1_r;
   reg         rx_s2_r;
   reg         rx_busy_r;
   reg  [3:0]  rt_r;
   reg  [3:0]  bit_r;
   reg  [1:0]  qual_r;
   reg  [1:0]  vhi_r;
   reg  [1:0]  smp_r;
   reg  [8:0]  shift_r;
   reg         noise_w_r;
   reg  [7:0]  quiet_cnt_r;
   reg         line_idle_r;
   reg         idle_allow_r;
   reg         rx_ev_r;        // frame finished this cycle
   reg         rx_stop_r;
   wire [7:0]  quiet_lim = {frame_len, 4'h0};
   wire [7:0]  rx_byte   = word9_r ? shift_r[7:0] : shift_r[8:1];
   wire        rx_msb    = word9_r ? shift_r[8] : shift_r[8];
   wire        vote      = maj3(smp_r[0], smp_r[1], rx_s2_r);
   // break: low stop vote and every data bit of this frame low (stale bit 0 ignored in 8-bit)
   wire        rx_brk    = ~vote & (rx_byte == 8'h00) & ~(word9_r & shift_r[8]);
   wire        quiet_hit = smp_tick_r & ~rx_busy_r & rx_s2_r & (quiet_cnt_r == quiet_lim - 8'h01);

   // sample engine: hunt, verify, vote per bit
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rx_s1_r <= 1'b1; rx_s2_r <= 1'b1; rx_busy_r <= 1'b0; rt_r <= 4'h0;
         bit_r <= 4'h0; qual_r <= 2'h0; vhi_r <= 2'h0; smp_r <= 2'h0;
         shift_r <= 9'h000; noise_w_r <= 1'b0; rx_ev_r <= 1'b0; rx_stop_r <= 1'b1;
         quiet_cnt_r <= 8'h00; line_idle_r <= 1'b0;
      end
      else if (ce)
      begin
         rx_s1_r <= rx_pin;
         rx_s2_r <= rx_s1_r;
         rx_ev_r <= 1'b0;
         if (!rx_on)
         begin
            rx_busy_r <= 1'b0;
            qual_r    <= 2'h0;
         end
         else if (smp_tick_r)
         begin
            // idle line counter runs while hunting
            if (rx_busy_r | ~rx_s2_r)
            begin
               quiet_cnt_r <= 8'h00;
               line_idle_r <= 1'b0;
            end
            else if (quiet_hit)
               line_idle_r <= 1'b1;
            else if (!line_idle_r)
               quiet_cnt_r <= quiet_cnt_r + 8'h01;
            if (!rx_busy_r)
            begin
               if (rx_s2_r)
                  qual_r <= (qual_r == `AST_QUALIFIERS) ? qual_r : qual_r + 2'h1;
               else if (qual_r == `AST_QUALIFIERS)
               begin
                  rx_busy_r <= 1'b1;
                  rt_r      <= 4'h1;
                  bit_r     <= 4'h0;
                  vhi_r     <= 2'h0;
                  noise_w_r <= 1'b0;
               end
               else
                  qual_r <= 2'h0;
            end
            else
            begin
               rt_r <= rt_r + 4'h1;
               if (rt_r == 4'h0)
                  bit_r <= bit_r + 4'h1;
               // start edge verification samples
               if ((bit_r == 4'h0) && ((rt_r == 4'h3) || (rt_r == 4'h5)))
                  vhi_r <= vhi_r + {1'b0, rx_s2_r};
               if ((bit_r == 4'h0) && (rt_r == 4'h7))
               begin
                  if (vhi_r + {1'b0, rx_s2_r} >= 2'h2)
                  begin
                     rx_busy_r <= 1'b0;
                     qual_r    <= 2'h0;
                  end
                  else if (vhi_r != 2'h0 || rx_s2_r)
                     noise_w_r <= 1'b1;
               end
               if (rt_r == `AST_SMP_A)
                  smp_r[0] <= rx_s2_r;
               if (rt_r == `AST_SMP_B)
                  smp_r[1] <= rx_s2_r;
               if (rt_r == `AST_SMP_C)
               begin
                  if ((smp_r[0] != smp_r[1]) || (smp_r[1] != rx_s2_r))
                     noise_w_r <= 1'b1;
                  if ((bit_r != 4'h0) && (bit_r < frame_len - 4'h1))
                     shift_r <= {vote, shift_r[8:1]};
                  if (bit_r == frame_len - 4'h1)
                  begin
                     rx_busy_r <= 1'b0;
                     rx_ev_r   <= 1'b1;
                     rx_stop_r <= vote;
                     // good stop or framing slip: forced qualifiers; break: wait high
                     qual_r    <= rx_brk ? 2'h0 : `AST_QUALIFIERS;
                  end
               end
            end
         end
      end
   end

   // ****************************************************
   // transmitter
   // ****************************************************
   reg  [10:0] tx_shift_r;
   reg  [3:0]  tx_left_r;
   reg         pre_pend_r;
   reg         brk_tail_r;     // one high bit owed after a break
   reg         brk_pend_r;     // a break request seen, kept until a bit tick loads it or transmit is disabled
   wire        tx_busy = (tx_left_r != 4'h0);
   wire        brk_want = (send_break | brk_pend_r) & tx_on;
   wire        tx_rise = wr_ctl2 & avs_writedata[`AST_C2_TX_ON] & ~tx_on;

   // frame sequencer on the bit tick
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tx_shift_r <= 11'h7FF;
         tx_left_r  <= 4'h0;
         pre_pend_r <= 1'b0;
         brk_tail_r <= 1'b0;
         brk_pend_r <= 1'b0;
         tx_pin_o   <= 1'b1;
         tx_pin_oe  <= 1'b0;
      end
      else if (ce)
      begin
         if (tx_rise)
            pre_pend_r <= 1'b1;
         tx_pin_oe <= tx_on | tx_busy;
         tx_pin_o  <= tx_busy ? tx_shift_r[0] : 1'b1;
         if (tx_bit_tick)
         begin
            if (tx_left_r > 4'h1)
            begin
               tx_shift_r <= {1'b1, tx_shift_r[10:1]};
               tx_left_r  <= tx_left_r - 4'h1;
            end
            else if (brk_want)
            begin
               tx_shift_r <= 11'h000;
               tx_left_r  <= frame_len;
               brk_tail_r <= 1'b1;
               brk_pend_r <= 1'b0;
            end
            else if (brk_tail_r)
            begin
               tx_shift_r <= 11'h7FF;
               tx_left_r  <= 4'h1;
               brk_tail_r <= 1'b0;
            end
            else if (tx_on & (pre_pend_r | tx_rise))
            begin
               tx_shift_r <= 11'h7FF;
               tx_left_r  <= frame_len;
               pre_pend_r <= 1'b0;
            end
            else if (tx_on & ~tx_empty_r)
            begin
               // start, data lsb first, ninth, stop
               tx_shift_r <= word9_r ? {1'b1, tx_bit_nine_r, tx_holding_r, 1'b0}
                                     : {2'h3, tx_holding_r, 1'b0};
               tx_left_r  <= frame_len;
            end
            else
               tx_left_r <= 4'h0;
         end
         // a short set-and-clear of send_break still owes one whole break frame
         if (wr_ctl2 & avs_writedata[`AST_C2_BREAK])
            brk_pend_r <= 1'b1;
         else if (!tx_on)
            brk_pend_r <= 1'b0;
      end
   end

   // ****************************************************
   // register writes and status flags
   // ****************************************************
   wire        load_tx   = tx_bit_tick & (tx_left_r <= 4'h1) & tx_on & ~brk_want
                           & ~brk_tail_r & ~(pre_pend_r | tx_rise) & ~tx_empty_r;
   wire        tx_end    = tx_bit_tick & (tx_left_r == 4'h1) & ~load_tx & ~brk_want
                           & ~brk_tail_r & ~(tx_on & (pre_pend_r | tx_rise));
   wire        flag_ok   = rx_on & ~rx_sleep;
   wire        addr_wake = rx_sleep & wake_addr_r & rx_msb;
   wire        rx_take   = rx_ev_r & rx_on & (flag_ok | addr_wake);
   wire        idle_wake = rx_on & rx_sleep & ~wake_addr_r & quiet_hit;
   wire        clr_rx    = rd_data;
   wire        clr_tx    = wr_data;

   // baud and control registers, flags; a set wins over a clear
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         baud_r <= `AST_BAUD_RST; ctrl_two_r <= `AST_CTRL_TWO_RST;
         tx_empty_r <= 1'b1; tx_done_r <= 1'b1;
         rx_full_r <= 1'b0; idle_r <= 1'b0; overrun_r <= 1'b0;
         noise_r <= 1'b0; fault_r <= 1'b0; arm_r <= 7'h00;
         idle_allow_r <= 1'b1; irq_r <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_lo & (idx == `AST_IDX_BAUD))
            baud_r <= avs_writedata[7:0];
         if (wr_ctl2)
         begin
            ctrl_two_r <= avs_writedata[7:0];
            if (line_idle_r & ~wake_addr_r & ~rx_sleep)
               ctrl_two_r[`AST_C2_SLEEP] <= 1'b0;
         end
         else if (idle_wake | (rx_ev_r & addr_wake & rx_on))
            ctrl_two_r[`AST_C2_SLEEP] <= 1'b0;
         if (rd_stat)
            arm_r <= status[7:1];
         else if (clr_tx | clr_rx)
            arm_r <= 7'h00;
         // transmit side
         if (load_tx)
            tx_empty_r <= 1'b1;
         else if (clr_tx & arm_r[6])
            tx_empty_r <= 1'b0;
         if (tx_end)
            tx_done_r <= 1'b1;
         else if (clr_tx & arm_r[5])
            tx_done_r <= 1'b0;
         // receive side
         if (rx_take & ~rx_full_r)
         begin
            rx_full_r <= 1'b1;
            noise_r   <= noise_w_r;
            fault_r   <= ~rx_stop_r;
            idle_allow_r <= 1'b1;
         end
         else if (clr_rx & arm_r[4])
            rx_full_r <= 1'b0;
         if (rx_take & rx_full_r)
            overrun_r <= 1'b1;
         else if (clr_rx & arm_r[2])
            overrun_r <= 1'b0;
         if (clr_rx & arm_r[1] & ~(rx_take & ~rx_full_r))
            noise_r <= 1'b0;
         if (clr_rx & arm_r[0] & ~(rx_take & ~rx_full_r))
            fault_r <= 1'b0;
         if (quiet_hit & flag_ok & idle_allow_r)
         begin
            idle_r       <= 1'b1;
            idle_allow_r <= 1'b0;
         end
         else if (clr_rx & arm_r[3])
            idle_r <= 1'b0;
         irq_r <= (ctrl_two_r[`AST_C2_TXE_IE] & tx_empty_r)
                | (ctrl_two_r[`AST_C2_TXD_IE] & tx_done_r)
                | (ctrl_two_r[`AST_C2_RXF_IE] & (rx_full_r | overrun_r))
                | (ctrl_two_r[`AST_C2_IDLE_IE] & idle_r);
      end
   end

   // registers that reset leaves alone
   always @(posedge clk)
   begin
      if (ce)
      begin
         if (wr_lo & (idx == `AST_IDX_CTRL_ONE))
         begin
            tx_bit_nine_r <= avs_writedata[`AST_C1_TX_NINE];
            word9_r       <= avs_writedata[`AST_C1_WORD9];
            wake_addr_r   <= avs_writedata[`AST_C1_WAKE_ADDR];
         end
         if (wr_data)
            tx_holding_r <= avs_writedata[7:0];
         if (rx_take & ~rx_full_r)
         begin
            rx_holding_r  <= rx_byte;
            rx_bit_nine_r <= shift_r[8];
         end
      end
   end

endmodule // ast_top

// >>> verif/ast_checker.sv
// checker for the serial transceiver top: bus handshake, tx timing, irq gating
// assumes ce held high and a baud divider of one, so one sample tick per clock
module ast_checker (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic        avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   input wire logic        tx_pin_o,
   input wire logic        tx_pin_oe,
   input wire logic        irq_r
);
   logic [7:0] ctl2_r;
   // shadow of ctrl two, taken at each accepted write
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         ctl2_r <= 8'h00;
      else if (avs_write && !avs_waitrequest && avs_address[7:2] == 6'h0F && avs_byteenable[0])
         ctl2_r <= avs_writedata[7:0];
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_bit_hold;
      ($stable(tx_pin_o) || !tx_pin_oe)[*8] ##1 ($stable(tx_pin_o) || !tx_pin_oe)[*7];
   endsequence
   sequence s_pre_ones;
      tx_pin_o[*8];
   endsequence
   chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered in one cycle");
   chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[7:2] < 6'h0D
      |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
   chk_bit_period: assert property ($changed(tx_pin_o) && tx_pin_oe && $past(tx_pin_oe)
      |=> s_bit_hold) else $error("tx bit shorter than sixteen ticks");
   chk_preamble_ones: assert property ($rose(tx_pin_oe) |-> s_pre_ones)
      else $error("tx does not open with ones");
   chk_oe_needs_on: assert property ($rose(tx_pin_oe) |-> ctl2_r[3])
      else $error("tx driven while disabled");
   chk_oe_drop_off: assert property ($fell(tx_pin_oe) |-> !ctl2_r[3])
      else $error("tx released while enabled");
   chk_irq_gated: assert property (ctl2_r[7:4] == 4'h0 && $past(ctl2_r[7:4]) == 4'h0
      && $past(ctl2_r[7:4], 2) == 4'h0 |-> !irq_r) else $error("irq with all enables clear");
endmodule // ast_checker

// >>> verif/ast_peer.sv
// remote serial peer: sends frames on rx_pin, captures frames from the tx line
// assumes sixteen clocks per bit; w9 is set by the bench to match word length
module ast_peer (
   input wire logic clk,
   output logic     rx_pin,
   input wire logic tx_pin_o,
   input wire logic tx_pin_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       w9 = 1'b0;
   logic [9:0] got[$];
   logic [9:0] f;
   int         i;
   wire        line = tx_pin_oe ? tx_pin_o : 1'b1; // pull-up while released
   initial rx_pin = 1'b1;
   // one frame out: start, data lsb first, stop
   task automatic send(input logic [8:0] d);
      int k;
      @(posedge clk) rx_pin <= 1'b0;
      repeat (16) @(posedge clk);
      for (k = 0; k < (w9 ? 9 : 8); k++)
      begin
         rx_pin <= d[k];
         repeat (16) @(posedge clk);
      end
      rx_pin <= 1'b1;
      repeat (16) @(posedge clk);
   endtask
   // capture: mid-bit samples, {stop, ninth, data}
   always
   begin
      @(negedge line);
      f = 10'h000;
      repeat (8) @(posedge clk);
      for (i = 0; i < (w9 ? 9 : 8); i++)
      begin
         repeat (16) @(posedge clk);
         f[i] = line;
      end
      repeat (16) @(posedge clk);
      f[9] = line;
      got.push_back(f);
   end
endmodule // ast_peer

// >>> verif/tb_async_serial_transceiver.sv
// self-checking bench for the serial transceiver top
// assumes ast_top, ast_peer and ast_checker are compiled before this file
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_async_serial_transceiver;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        ce = 1'b1;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   wire         avs_waitrequest, tx_pin_o, tx_pin_oe, irq_r, rx_pin;
   wire  [31:0] avs_readdata;
   int          error_cnt = 0;
   int          cmp_count = 0;
   int          j;
   logic [7:0]  rd, st;
   logic [9:0]  exp_q[$];
   ast_top #(.TICK_BASE(16'h0001)) uut (.clk, .rst_b, .ce, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_waitrequest, .avs_readdata, .rx_pin, .tx_pin_o,
      .tx_pin_oe, .irq_r);
   ast_peer peer (.clk, .rx_pin, .tx_pin_o, .tx_pin_oe);
   initial forever #2 clk = ~clk;
   // expected frame and expected irq level
   function automatic logic [9:0] frm(input logic [8:0] d, input logic w9);
      return {1'b1, w9 & d[8], d[7:0]};
   endfunction
   function automatic logic irq_exp(input logic [7:0] en, input logic [7:0] s);
      return |(en[7:4] & {s[7], s[6], s[5] | s[3], s[4]});
   endfunction
   // one avalon transfer, held until waitrequest is sampled low
   task bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] r);
      @(posedge clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h0, wd};
      avs_byteenable <= {3'($urandom), 1'b1};
      // only the watchdog ends this wait
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      r = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task poll(input int b);
      int n;
      n = 0;
      do begin bus(0, 6'h10, 8'h00, st); n++; end while (st[b] !== 1'b1 && n < 3000);
      `CHK("status bit", 1'b1, st[b])
   endtask
   task xmit(input logic [8:0] d);
      poll(7);
      bus(1, 6'h11, d[7:0], rd);
      exp_q.push_back(frm(d, peer.w9));
   endtask
   task recv(input logic [8:0] d);
      peer.send(d);
      poll(5);
      bus(0, 6'h11, 8'h00, rd);
      `CHK("rx data", d[7:0], rd)
      bus(0, 6'h10, 8'h00, st);
      `CHK("rx_full clear", 1'b0, st[5])
   endtask
   task drain;
      int n;
      logic [9:0] e, g;
      n = 0;
      while (peer.got.size() < exp_q.size() && n < 5000) begin @(posedge clk); n++; end
      while (exp_q.size() > 0)
      begin
         e = exp_q.pop_front();
         g = peer.got.size() > 0 ? peer.got.pop_front() : 10'h3FF;
         `CHK("tx frame", e, g)
      end
      `CHK("extra frames", 0, peer.got.size())
   endtask
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // main sequence
   initial
   begin
      void'($urandom(22));
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      bus(0, 6'h0F, 8'h00, rd);
      `CHK("ctrl two reset", 8'h00, rd)
      bus(0, 6'h10, 8'h00, rd);
      `CHK("status reset", 8'hC0, rd)
      bus(0, 6'h02, 8'h00, rd);
      `CHK("unmapped", 8'h00, rd)
      bus(1, 6'h0D, 8'h00, rd);
      bus(1, 6'h0E, 8'h00, rd);
      bus(1, 6'h0F, 8'h0C, rd);
      for (j = 0; j < 7; j++)
         xmit(j < 4 ? {1'b0, 8'h00 | ((j == 1) ? 8'hFF : (j == 2) ? 8'h01 : (j == 3) ? 8'h80 : 8'h00)}
                    : {1'b0, 8'($urandom)});
      drain;
      bus(1, 6'h0F, 8'h0D, rd);
      bus(1, 6'h0F, 8'h0C, rd);
      exp_q.push_back(10'h000);
      drain;
      bus(1, 6'h0E, 8'h50, rd);
      peer.w9 = 1'b1;
      xmit(9'h1A5);
      drain;
      recv(9'h13C);
      bus(0, 6'h0E, 8'h00, rd);
      `CHK("rx ninth bit", 1'b1, rd[7])
      bus(1, 6'h0E, 8'h00, rd);
      peer.w9 = 1'b0;
      recv(9'h000);
      recv(9'h0FF);
      recv({1'b0, 8'($urandom)});
      for (j = 0; j < 4; j++)
      begin
         bus(1, 6'h0F, (8'h80 >> j) | 8'h0C, rd);
         bus(0, 6'h10, 8'h00, st);
         repeat (3) @(posedge clk);
         `CHK("irq", irq_exp(8'h80 >> j, st), irq_r)
      end
      bus(1, 6'h0F, 8'h0C, rd);
      xmit({1'b0, 8'($urandom)});
      poll(7);
      bus(1, 6'h0F, 8'h04, rd);
      drain;
      repeat (16) @(posedge clk);
      `CHK("tx released", 1'b0, tx_pin_oe)
      tally_and_finish;
   end
   // watchdog
   initial
   begin
      #200000;
      error_cnt++;
      tally_and_finish;
   end
endmodule // tb_async_serial_transceiver
bind ast_top ast_checker chk (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_waitrequest, .avs_readdata, .tx_pin_o, .tx_pin_oe, .irq_r);
